/* hw/fhdt_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module fhdt_fifo #(
  parameter int W     = 224,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  // honest flags from the occupancy count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage carries no reset, only data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

/* hw/fhdt_framer.sv */
// internal frame header builder (extraction) and parser (injection), bits 223:0
`timescale 1ns/1ns

module fhdt_framer #(
  parameter int         DEPTH        = fhdt_pkg::FIFO_DEPTH,
  parameter logic [7:0] PREFIX_BYTES = fhdt_pkg::PREFIX_BYTES_DEF
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // extraction build request
  input  wire logic          build_valid,
  output logic               build_ready,
  input  wire logic [63:0]   build_dest,
  input  wire logic [79:0]   build_stack,
  input  wire logic [47:0]   build_low,
  // extraction header out
  output logic               xtr_valid,
  input  wire logic          xtr_ready,
  output logic [223:0]       xtr_header,
  // injection header in
  input  wire logic          inj_valid,
  output logic               inj_ready,
  input  wire logic [223:0]  inj_header,
  input  wire logic [3:0]    inj_first_nibble,
  // injection decoded fields out
  output logic               dec_valid,
  input  wire logic          dec_ready,
  output logic [2:0]         destination_format_select,
  output logic               format_error,
  output logic [52:0]        egress_port_mask,
  output logic               route_ttl_update,
  output logic               mac_swap_request,
  output logic [1:0]         tag_protocol_select,
  output logic [3:0]         tpid_onehot,
  output logic [9:0]         generic_index,
  output logic               virtual_switch_instance,
  output logic               protection_active_flag,
  output logic [5:0]         pdu_halfword_offset,
  output logic [7:0]         pdu_start_bytes,
  output logic [2:0]         pdu_class,
  output logic               pdu_is_oam,
  output logic               pdu_is_ptp,
  output logic [15:0]        classifier_match_result,
  output logic [7:0]         label_ttl_value,
  output logic               label_bottom_flag,
  output logic [2:0]         header_after_strip,
  output logic [4:0]         halfword_strip_count,
  output logic [5:0]         strip_bytes,
  output logic [6:0]         egress_router_leg,
  output logic [47:0]        next_hop_dest_mac,
  output logic [9:0]         multicast_group_index,
  output logic [6:0]         routed_copy_count,
  output logic [79:0]        stack_slot,
  // transmit stripping
  input  wire logic          keep_header_sel,
  input  wire logic          prefix_present,
  output logic [7:0]         tx_strip_len
);

  // ****************************************
  // shared decoding
  // ****************************************

  // defined bits of the destination section for a format; reserved codes keep nothing
  function automatic logic [63:0] dst_mask(input logic [2:0] fmt);
    case (fmt)
      fhdt_pkg::FMT_TUNNEL:    dst_mask = fhdt_pkg::MASK_TUNNEL;
      fhdt_pkg::FMT_UNICAST:   dst_mask = fhdt_pkg::MASK_UNICAST;
      fhdt_pkg::FMT_MULTICAST: dst_mask = fhdt_pkg::MASK_MULTICAST;
      fhdt_pkg::FMT_PORTLIST:  dst_mask = fhdt_pkg::MASK_PORTLIST;
      default:                 dst_mask = fhdt_pkg::MASK_NONE;
    endcase
  endfunction

  // ****************************************
  // arrival time counter
  // ****************************************
  // one clock, so time advances a period per edge
  logic [31:0] ns_count;

  // free running nanosecond time, wraps after about 4.3 s
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ns_count <= fhdt_pkg::TS_RESET;
    end else begin
      ns_count <= ns_count + fhdt_pkg::NS_PER_CYCLE;
    end
  end

  // ****************************************
  // extraction build path
  // ****************************************
  // reserved bits are masked, never refused
  wire [2:0]   b_fmt    = build_low[fhdt_pkg::FMT_LO +: fhdt_pkg::FMT_W];
  wire [63:0]  b_dest   = build_dest & dst_mask(b_fmt);
  // time sampled when the request is taken, not when it leaves
  wire [223:0] b_header = {ns_count, b_dest, build_stack, build_low};

  // fifo head side
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [223:0] fifo_out_data;

  // sixteen headers absorb extraction bursts; full stalls the requester
  fhdt_fifo #(
    .W     (fhdt_pkg::HDR_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (build_valid),
    .in_ready  (build_ready),
    .in_data   (b_header),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // output register so the header port comes straight from flops
  assign fifo_out_ready = !xtr_valid || xtr_ready;

  // header register loads when empty or taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xtr_valid  <= 1'b0;
      xtr_header <= '0;
    end else if (fifo_out_ready) begin
      xtr_valid  <= fifo_out_valid;
      xtr_header <= fifo_out_data;
    end
  end

  // ****************************************
  // injection parse path: field extraction
  // ****************************************
  // injected word, fields cut straight off it
  wire [223:0] h        = inj_header;
  wire [2:0]   p_fmt    = h[fhdt_pkg::FMT_LO +: fhdt_pkg::FMT_W];
  wire [63:0]  p_dst    = h[fhdt_pkg::DST_LO +: fhdt_pkg::DST_W];
  wire [63:0]  p_mask   = dst_mask(p_fmt);
  wire         is_tun   = (p_fmt == fhdt_pkg::FMT_TUNNEL);
  wire         is_uc    = (p_fmt == fhdt_pkg::FMT_UNICAST);
  wire         is_mc    = (p_fmt == fhdt_pkg::FMT_MULTICAST);
  wire         is_pl    = (p_fmt == fhdt_pkg::FMT_PORTLIST);
  wire         fmt_rsv  = !(is_tun || is_uc || is_mc || is_pl);
  // undocumented tunnel bits are not checked, only ignored
  wire [63:0]  chk_mask = is_tun ? ~(p_mask | 64'h0000_0000_0000_0380) : ~p_mask;
  wire         rsv_set  = (p_dst & chk_mask) != 64'h0000_0000_0000_0000;

  // tunnel fields
  wire [1:0]   p_tpid   = h[fhdt_pkg::TPID_LO +: fhdt_pkg::TPID_W];
  wire         p_gkind  = h[fhdt_pkg::GKIND_BIT];
  wire [5:0]   p_off    = h[fhdt_pkg::PDUOFF_LO +: fhdt_pkg::PDUOFF_W];
  wire [2:0]   p_cls    = h[fhdt_pkg::PDUCLS_LO +: fhdt_pkg::PDUCLS_W];
  wire [1:0]   p_after  = h[fhdt_pkg::AFTER_LO +: fhdt_pkg::AFTER_W];
  wire [4:0]   p_strip  = h[fhdt_pkg::STRIP_LO +: fhdt_pkg::STRIP_W];
  wire [3:0]   p_onehot = 4'h1 << p_tpid;
  wire         cls_oam  = (p_cls == fhdt_pkg::PDU_OAM_Y) ||
                          (p_cls == fhdt_pkg::PDU_OAM_TP);
  wire         cls_ptp  = (p_cls == fhdt_pkg::PDU_PTP) ||
                          (p_cls == fhdt_pkg::PDU_PTP_IP4) ||
                          (p_cls == fhdt_pkg::PDU_PTP_IP6);
  wire         tun_bad  = is_tun && (!p_gkind ||
                          (p_cls == fhdt_pkg::PDU_RSV) || (p_after == 2'h3));
  // pdu start counted from frame start: stripped halfwords plus offset
  wire [7:0]   p_pdu    = {({2'h0, p_strip} + {1'b0, p_off}), 1'b0};
  wire [5:0]   p_sbytes = {p_strip, 1'b0};

  // what follows the stripped region; a control word is told apart by its first nibble
  wire [2:0]   cw_kind  = (inj_first_nibble == fhdt_pkg::NIB_IPV4) ? fhdt_pkg::KIND_IPV4 :
                          (inj_first_nibble == fhdt_pkg::NIB_IPV6) ? fhdt_pkg::KIND_IPV6 :
                          fhdt_pkg::KIND_MPLS_CW;
  wire [2:0]   p_kind   = (p_after == fhdt_pkg::AFTER_ETH)  ? fhdt_pkg::KIND_ETH  :
                          (p_after == fhdt_pkg::AFTER_CW)   ? cw_kind            :
                          (p_after == fhdt_pkg::AFTER_MPLS) ? fhdt_pkg::KIND_SHIM :
                          fhdt_pkg::KIND_RSV;

  // router leg sits at a different place in the two routing formats
  wire [6:0]   p_leg    = is_uc ? h[fhdt_pkg::UC_LEG_LO +: fhdt_pkg::LEG_W] :
                          is_mc ? h[fhdt_pkg::MC_LEG_LO +: fhdt_pkg::LEG_W] : 7'h00;

  // ****************************************
  // injection parse path: decoded register stage
  // ****************************************
  assign inj_ready = !dec_valid || dec_ready;
  wire   take      = inj_valid && inj_ready;

  // valid holds until the consumer takes it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_valid <= 1'b0;
    end else if (inj_ready) begin
      dec_valid <= inj_valid;
    end
  end

  // fields of other formats read as zero so a consumer cannot misuse them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      destination_format_select <= 3'h0;
      format_error              <= 1'b0;
      egress_port_mask          <= '0;
      route_ttl_update          <= 1'b0;
      mac_swap_request          <= 1'b0;
      tag_protocol_select       <= 2'h0;
      tpid_onehot               <= 4'h0;
      generic_index             <= 10'h000;
      virtual_switch_instance   <= 1'b0;
      protection_active_flag    <= 1'b0;
      pdu_halfword_offset       <= 6'h00;
      pdu_start_bytes           <= 8'h00;
      pdu_class                 <= 3'h0;
      pdu_is_oam                <= 1'b0;
      pdu_is_ptp                <= 1'b0;
      classifier_match_result   <= 16'h0000;
      label_ttl_value           <= 8'h00;
      label_bottom_flag         <= 1'b0;
      header_after_strip        <= 3'h0;
      halfword_strip_count      <= 5'h00;
      strip_bytes               <= 6'h00;
      egress_router_leg         <= 7'h00;
      next_hop_dest_mac         <= '0;
      multicast_group_index     <= 10'h000;
      routed_copy_count         <= 7'h00;
      stack_slot                <= '0;
    end else if (take) begin
      destination_format_select <= p_fmt;
      format_error              <= fmt_rsv || rsv_set || tun_bad;
      egress_port_mask          <= is_pl ? h[fhdt_pkg::PORTS_LO +: fhdt_pkg::PORTS_W]
                                         : 53'h0;
      route_ttl_update          <= is_tun && h[fhdt_pkg::TTLUPD_BIT];
      mac_swap_request          <= is_tun && h[fhdt_pkg::MACSWP_BIT];
      tag_protocol_select       <= is_tun ? p_tpid : 2'h0;
      tpid_onehot               <= is_tun ? p_onehot : 4'h0;
      generic_index             <= is_tun ? h[fhdt_pkg::GIDX_LO +: fhdt_pkg::GIDX_W]
                                          : 10'h000;
      virtual_switch_instance   <= is_tun && p_gkind;
      protection_active_flag    <= is_tun && h[fhdt_pkg::PROT_BIT];
      pdu_halfword_offset       <= is_tun ? p_off : 6'h00;
      pdu_start_bytes           <= is_tun ? p_pdu : 8'h00;
      pdu_class                 <= is_tun ? p_cls : 3'h0;
      pdu_is_oam                <= is_tun && cls_oam;
      pdu_is_ptp                <= is_tun && cls_ptp;
      classifier_match_result   <= is_tun ? h[fhdt_pkg::CLRES_LO +: fhdt_pkg::CLRES_W]
                                          : 16'h0000;
      label_ttl_value           <= is_tun ? h[fhdt_pkg::LTTL_LO +: fhdt_pkg::LTTL_W]
                                          : 8'h00;
      label_bottom_flag         <= is_tun && h[fhdt_pkg::LBOT_BIT];
      header_after_strip        <= is_tun ? p_kind : 3'h0;
      halfword_strip_count      <= is_tun ? p_strip : 5'h00;
      strip_bytes               <= is_tun ? p_sbytes : 6'h00;
      egress_router_leg         <= p_leg;
      next_hop_dest_mac         <= is_uc ? h[fhdt_pkg::UC_MAC_LO +: fhdt_pkg::MAC_W]
                                         : 48'h0;
      multicast_group_index     <= is_mc ? h[fhdt_pkg::MC_GRP_LO +: fhdt_pkg::GRP_W]
                                         : 10'h000;
      routed_copy_count         <= is_mc ? h[fhdt_pkg::MC_CNT_LO +: fhdt_pkg::CNT_W]
                                         : 7'h00;
      stack_slot                <= h[fhdt_pkg::STK_LO +: fhdt_pkg::STK_W];
    end
  end

  // ****************************************
  // transmit stripping length
  // ****************************************
  // bytes cut ahead of the frame on transmit
  wire [7:0] hdr_len  = 8'(fhdt_pkg::HDR_BYTES);
  wire [7:0] pre_len  = prefix_present ? PREFIX_BYTES : 8'h00;
  wire [7:0] next_tx_strip_len = keep_header_sel ? 8'h00 : hdr_len + pre_len;

  // a kept header leaves the frame untouched, prefix included
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_strip_len <= 8'h00;
    end else begin
      tx_strip_len <= next_tx_strip_len;
    end
  end

endmodule

/* pkg/fhdt_pkg.sv */
// constants for the internal frame header framer: field positions, encodings, reset values
package fhdt_pkg;

  // ****************************************
  // header geometry
  // ****************************************
  localparam int HDR_BYTES = 28;
  localparam int HDR_W     = 224;
  localparam int TS_LO     = 192;             // arrival time, 223:192
  localparam int TS_W      = 32;
  localparam int DST_LO    = 128;             // destination section, 191:128
  localparam int DST_W     = 64;
  localparam int STK_LO    = 48;              // stacking header slot, 127:48
  localparam int STK_W     = 80;
  localparam int LOW_W     = 48;              // forwarding and below, 47:0
  localparam int FMT_LO    = 38;              // destination format select, 40:38
  localparam int FMT_W     = 3;

  // ****************************************
  // destination format codes
  // ****************************************
  localparam logic [2:0] FMT_TUNNEL    = 3'h0;
  localparam logic [2:0] FMT_UNICAST   = 3'h1;
  localparam logic [2:0] FMT_MULTICAST = 3'h2;
  localparam logic [2:0] FMT_PORTLIST  = 3'h3;

  // defined bits of the destination section per format, relative to bit 128
  localparam logic [63:0] MASK_TUNNEL    = 64'h3cff_ffff_ffff_fc7f;
  localparam logic [63:0] MASK_UNICAST   = 64'h007f_ffff_ffff_ffff;
  localparam logic [63:0] MASK_MULTICAST = 64'h0000_0000_00ff_ffff;
  localparam logic [63:0] MASK_PORTLIST  = 64'h001f_ffff_ffff_ffff;
  localparam logic [63:0] MASK_NONE      = 64'h0000_0000_0000_0000;

  // ****************************************
  // field positions inside the header
  // ****************************************
  localparam int PORTS_LO   = 128;  localparam int PORTS_W  = 53;
  localparam int TTLUPD_BIT = 189;
  localparam int MACSWP_BIT = 188;
  localparam int TPID_LO    = 186;  localparam int TPID_W   = 2;
  localparam int GIDX_LO    = 174;  localparam int GIDX_W   = 10;
  localparam int GKIND_BIT  = 173;
  localparam int PROT_BIT   = 172;
  localparam int PDUOFF_LO  = 166;  localparam int PDUOFF_W = 6;
  localparam int PDUCLS_LO  = 163;  localparam int PDUCLS_W = 3;
  localparam int CLRES_LO   = 147;  localparam int CLRES_W  = 16;
  localparam int LTTL_LO    = 139;  localparam int LTTL_W   = 8;
  localparam int LBOT_BIT   = 138;
  localparam int AFTER_LO   = 133;  localparam int AFTER_W  = 2;
  localparam int STRIP_LO   = 128;  localparam int STRIP_W  = 5;
  localparam int UC_LEG_LO  = 176;  localparam int LEG_W    = 7;
  localparam int UC_MAC_LO  = 128;  localparam int MAC_W    = 48;
  localparam int MC_GRP_LO  = 142;  localparam int GRP_W    = 10;
  localparam int MC_LEG_LO  = 135;
  localparam int MC_CNT_LO  = 128;  localparam int CNT_W    = 7;

  // ****************************************
  // field encodings
  // ****************************************
  localparam logic [2:0] PDU_NONE     = 3'h0;
  localparam logic [2:0] PDU_OAM_Y    = 3'h1;
  localparam logic [2:0] PDU_OAM_TP   = 3'h2;
  localparam logic [2:0] PDU_PTP      = 3'h3;
  localparam logic [2:0] PDU_PTP_IP4  = 3'h4;
  localparam logic [2:0] PDU_PTP_IP6  = 3'h5;
  localparam logic [2:0] PDU_RSV      = 3'h6;
  localparam logic [2:0] PDU_SAM      = 3'h7;
  localparam logic [1:0] AFTER_ETH    = 2'h0;
  localparam logic [1:0] AFTER_CW     = 2'h1;
  localparam logic [1:0] AFTER_MPLS   = 2'h2;
  localparam logic [3:0] NIB_IPV4     = 4'h4;
  localparam logic [3:0] NIB_IPV6     = 4'h6;
  // decoded kind of what follows stripping
  localparam logic [2:0] KIND_ETH     = 3'h0;
  localparam logic [2:0] KIND_IPV4    = 3'h1;
  localparam logic [2:0] KIND_IPV6    = 3'h2;
  localparam logic [2:0] KIND_MPLS_CW = 3'h3;
  localparam logic [2:0] KIND_SHIM    = 3'h4;
  localparam logic [2:0] KIND_RSV     = 3'h7;

  // ****************************************
  // timing and reset values
  // ****************************************
  localparam int          CLK_MHZ      = 100;
  localparam int          CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam logic [31:0] NS_PER_CYCLE = 32'(CLK_PERIOD_NS);
  localparam logic [31:0] TS_RESET     = 32'h0000_0000;
  localparam logic [7:0]  PREFIX_BYTES_DEF = 8'h10;
  localparam int          FIFO_DEPTH   = 16;

endpackage

/* test/fhdt_framer_assertions.sv */
// port-level checks of the header framer
`timescale 1ns/1ns
module fhdt_framer_chk #(
  parameter logic [7:0] PREFIX_BYTES = 8'h10
) (
  input wire logic         clk, sys_rst, build_valid, build_ready, xtr_valid, xtr_ready,
  input wire logic         inj_valid, inj_ready, dec_valid, dec_ready,
  input wire logic         keep_header_sel, prefix_present,
  input wire logic [223:0] inj_header,
  input wire logic [2:0]   destination_format_select,
  input wire logic [1:0]   tag_protocol_select,
  input wire logic [3:0]   tpid_onehot,
  input wire logic [4:0]   halfword_strip_count,
  input wire logic [5:0]   strip_bytes, pdu_halfword_offset,
  input wire logic [7:0]   pdu_start_bytes, tx_strip_len
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // *****
  // assertions, $past guarded so the reset cycle never counts
  // *****
  chk_strip_len_follows: assert property (
    !$past(sys_rst) |-> tx_strip_len == ($past(keep_header_sel) ? 8'h00
      : 8'h1c + ($past(prefix_present) ? PREFIX_BYTES : 8'h00))) else $error("strip length");
  chk_xtr_answer: assert property (
    build_valid && build_ready && !xtr_valid |-> ##[1:2] xtr_valid) else $error("no header");
  chk_xtr_stands: assert property (
    xtr_valid && !xtr_ready |=> xtr_valid) else $error("header dropped");
  chk_inj_refuse: assert property (
    inj_ready == (!dec_valid || dec_ready)) else $error("parse ready");
  chk_dec_hold: assert property (
    dec_valid && !dec_ready |=> dec_valid && $stable(halfword_strip_count)) else $error("hold");
  chk_fmt_decode: assert property (
    inj_valid && inj_ready |=> dec_valid && destination_format_select == $past(inj_header[40:38]))
    else $error("format select");
  chk_tpid_onehot: assert property (
    dec_valid && destination_format_select == 3'h0
      |-> tpid_onehot == (4'h1 << tag_protocol_select)) else $error("tpid");
  chk_strip_bytes: assert property (
    dec_valid |-> strip_bytes == {halfword_strip_count, 1'b0}) else $error("strip bytes");
  chk_pdu_start: assert property (
    dec_valid |-> pdu_start_bytes == 8'({halfword_strip_count, 1'b0} + {pdu_halfword_offset, 1'b0}))
    else $error("pdu start");
  cover property (build_valid && !build_ready);
  cover property (dec_valid && !dec_ready && inj_valid);
  cover property (xtr_valid && !xtr_ready);
endmodule
bind fhdt_framer fhdt_framer_chk #(.PREFIX_BYTES(PREFIX_BYTES)) chk_i (.clk, .sys_rst,
  .build_valid, .build_ready, .xtr_valid, .xtr_ready, .inj_valid, .inj_ready, .dec_valid,
  .dec_ready, .keep_header_sel, .prefix_present, .inj_header, .destination_format_select,
  .tag_protocol_select, .tpid_onehot, .halfword_strip_count, .strip_bytes, .pdu_halfword_offset,
  .pdu_start_bytes, .tx_strip_len);

/* test/fhdt_host_model.sv */
// host side: takes extracted headers, stalls on command
`timescale 1ns/1ns
module fhdt_host_model (
  input wire logic         clk, sys_rst, stall, xtr_valid,
  input wire logic [223:0] xtr_header,
  output logic             xtr_ready
);
  logic [223:0] got[$];
  // ready follows the stall command and reset, never the valid
  assign xtr_ready = !stall && !sys_rst;
  // whole header taken on the edge where both are high
  always @(posedge clk) if (!sys_rst && xtr_valid && xtr_ready) got.push_back(xtr_header);
endmodule

/* test/testbench.sv */
// self-checking bench for the header framer
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [2:0] fmt; logic [63:0] dest; logic [3:0] nib; logic [85:0] exp;}
    fhdt_row_t;
  logic clk, sys_rst, build_valid, build_ready, xtr_valid, xtr_ready, inj_valid, inj_ready;
  logic dec_valid, dec_ready, keep_header_sel, prefix_present, stall, format_error;
  logic [63:0] build_dest; logic [79:0] build_stack; logic [47:0] build_low;
  logic [223:0] inj_header, xtr_header; logic [3:0] inj_first_nibble; logic [52:0] egress_port_mask;
  logic [2:0] header_after_strip; logic [6:0] egress_router_leg, routed_copy_count;
  logic [9:0] multicast_group_index; logic [4:0] halfword_strip_count; logic [7:0] tx_strip_len;
  logic route_ttl_update, mac_swap_request, virtual_switch_instance, protection_active_flag;
  logic pdu_is_oam, pdu_is_ptp, label_bottom_flag; logic [1:0] tag_protocol_select;
  logic [3:0] tpid_onehot; logic [9:0] generic_index; logic [2:0] pdu_class;
  logic [2:0] destination_format_select; logic [5:0] pdu_halfword_offset, strip_bytes;
  logic [7:0] pdu_start_bytes, label_ttl_value; logic [15:0] classifier_match_result;
  logic [47:0] next_hop_dest_mac; logic [79:0] stack_slot;
  int failures = 0, samples_checked = 0, n;
  fhdt_row_t rows[14];
  fhdt_framer #(.DEPTH(16), .PREFIX_BYTES(8'h10)) fhdt_framer_i (.clk, .sys_rst, .build_valid,
    .build_ready, .build_dest, .build_stack, .build_low, .xtr_valid, .xtr_ready, .xtr_header,
    .inj_valid, .inj_ready, .inj_header, .inj_first_nibble, .dec_valid, .dec_ready,
    .destination_format_select, .format_error, .egress_port_mask, .route_ttl_update,
    .mac_swap_request, .tag_protocol_select, .tpid_onehot, .generic_index,
    .virtual_switch_instance, .protection_active_flag, .pdu_halfword_offset,
    .pdu_start_bytes, .pdu_class, .pdu_is_oam, .pdu_is_ptp, .classifier_match_result,
    .label_ttl_value, .label_bottom_flag, .header_after_strip, .halfword_strip_count,
    .strip_bytes, .egress_router_leg, .next_hop_dest_mac, .multicast_group_index,
    .routed_copy_count, .stack_slot, .keep_header_sel, .prefix_present, .tx_strip_len);
  fhdt_host_model fhdt_host_model_i (.clk, .sys_rst, .stall, .xtr_valid, .xtr_header, .xtr_ready);
  // *****
  // clock, helpers, watchdog
  // *****
  initial begin clk = 0; forever #5 clk = ~clk; end
  function automatic logic [223:0] mk(input logic [2:0] f, input logic [63:0] d);
    return {32'h0, d, 80'h0, 7'h0, f, 38'h0};
  endfunction
  task automatic tick; @(posedge clk); #1; endtask
  task automatic check(input logic [223:0] seen, input logic [223:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // generous: the whole sequence needs about a hundred cycles
  initial begin repeat (5000) @(posedge clk); failures++; stop_test(); end
  // *****
  // main sequence
  // *****
  initial begin
    {sys_rst, build_valid, inj_valid, keep_header_sel, prefix_present, stall, dec_ready} = 7'h47;
    build_dest = '0; build_stack = 80'h1234_5678_9abc_def0_1357;
    build_low = '0; inj_header = '0; inj_first_nibble = 4'h0;
    rows = '{'{3'h0, 64'h0c00_2000_0000_0003, 4'h0, {1'h0, 3'h0, 24'h0, 5'h3, 53'h0}},
      '{3'h0, 64'h0400_2000_0000_0020, 4'h4, {1'h0, 3'h1, 82'h0}},
      '{3'h0, 64'h0800_2000_0000_0020, 4'h6, {1'h0, 3'h2, 82'h0}},
      '{3'h0, 64'h0000_2000_0000_0020, 4'h9, {1'h0, 3'h3, 82'h0}},
      '{3'h0, 64'h0000_2000_0000_0040, 4'h0, {1'h0, 3'h4, 82'h0}},
      '{3'h0, 64'h0000_2000_0000_0060, 4'h0, {1'h1, 3'h7, 82'h0}},
      '{3'h0, 64'h0000_0000_0000_0000, 4'h0, {1'h1, 85'h0}},
      '{3'h0, 64'h0000_2000_0000_0380, 4'h0, {1'h0, 85'h0}},
      '{3'h0, 64'h8000_2000_0000_0000, 4'h0, {1'h1, 85'h0}},
      '{3'h0, 64'h0000_2030_0000_0000, 4'h0, {1'h1, 85'h0}},
      '{3'h1, 64'h0055_0123_4567_89ab, 4'h0, {4'h0, 7'h55, 75'h0}},
      '{3'h2, 64'h0000_0000_00a9_5991, 4'h0, {4'h0, 7'h33, 10'h2a5, 7'h11, 58'h0}},
      '{3'h3, 64'h001a_5a5a_5a5a_5a5a, 4'h0, {33'h0, 53'h1a_5a5a_5a5a_5a5a}},
      '{3'h5, 64'h0, 4'h0, {1'h1, 85'h0}}};
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
    check({xtr_valid, dec_valid, tx_strip_len}, 0);
    // ordinary parse cases back to back
    for (int i = 0; i < 14; i++) begin
      inj_valid = 1; inj_header = mk(rows[i].fmt, rows[i].dest); inj_first_nibble = rows[i].nib;
      tick();
      check({format_error, header_after_strip, egress_router_leg, multicast_group_index,
        routed_copy_count, halfword_strip_count, egress_port_mask}, rows[i].exp);
    end
    // consumer stalls with a new header waiting: the first result must stand
    inj_header = mk(3'h0, rows[0].dest); tick();
    dec_ready = 0; inj_header = mk(3'h1, rows[10].dest); repeat (3) tick();
    check({inj_ready, halfword_strip_count}, 6'h03);
    dec_ready = 1; tick();
    inj_header = {32'h0, 2'h0, 2'h3, 2'h2, 2'h0, 10'h2b5, 2'h3, 6'h05, 3'h4, 16'hbeef, 8'h40,
      1'b1, 5'h0, 5'h07, build_stack, 48'h0};
    check({egress_router_leg, next_hop_dest_mac}, {7'h55, 48'h0123_4567_89ab});
    // every tunnel field but header_after_strip at once, stacking header in its slot
    tick(); inj_valid = 0;
    check({destination_format_select, format_error, route_ttl_update, mac_swap_request,
      tag_protocol_select, tpid_onehot, generic_index, virtual_switch_instance,
      protection_active_flag, pdu_halfword_offset, pdu_start_bytes, pdu_class, pdu_is_oam,
      pdu_is_ptp, classifier_match_result, label_ttl_value, label_bottom_flag,
      halfword_strip_count, strip_bytes},
      {4'h0, 2'h3, 2'h2, 4'h4, 10'h2b5, 2'h3, 6'h05, 8'h18, 3'h4, 2'h1, 16'hbeef, 8'h40, 1'b1,
      5'h07, 6'h0e});
    check(stack_slot, build_stack);
    // three headers back to back, host stalled
    build_valid = 1; build_dest = '1;
    foreach (rows[i]) if (i < 3) begin build_low = {7'h0, 3'(3 + i) & 3'h3, 38'h15}; tick(); end
    build_valid = 0; stall = 0; repeat (10) tick();
    check(fhdt_host_model_i.got.size(), 3);
    check(fhdt_host_model_i.got[0][191:128], 64'h001f_ffff_ffff_ffff);
    check(fhdt_host_model_i.got[1][191:128], 64'h3cff_ffff_ffff_fc7f);
    check(fhdt_host_model_i.got[2][191:128], 64'h007f_ffff_ffff_ffff);
    check(fhdt_host_model_i.got[1][223:192] - fhdt_host_model_i.got[0][223:192], 10);
    check(fhdt_host_model_i.got[2][127:0], {build_stack, build_low});
    // fill until refused, then drain
    fhdt_host_model_i.got.delete(); stall = 1; build_valid = 1; n = 0;
    while (build_ready === 1'b1 && n < 40) begin tick(); n++; end
    build_valid = 0; stall = 0; repeat (30) tick();
    check(n, 17);
    check({fhdt_host_model_i.got.size(), xtr_valid}, {32'd17, 1'b0});
    // strip length for every keep/prefix setting
    for (int k = 0; k < 4; k++) begin
      {keep_header_sel, prefix_present} = 2'(k); tick();
      check(tx_strip_len, k[1] ? 8'h00 : 8'h1c + (k[0] ? 8'h10 : 8'h00));
    end
    // reset in mid-run with headers pending and the host stalled
    keep_header_sel = 0; stall = 1; build_valid = 1; repeat (3) tick();
    build_valid = 0; sys_rst = 1; tick();
    sys_rst = 0;
    check({xtr_valid, dec_valid, build_ready, inj_ready, tx_strip_len}, 12'h300);
    tick();
    check(tx_strip_len, 8'h2c);
    stop_test();
  end
endmodule
